// ### power_reset_sequencer_pkg.sv
// constants and types shared by the power and reset sequencer
package power_reset_sequencer_pkg;

   // interrupt status register
   localparam int                STAT_W         = 8;
   localparam logic [STAT_W-1:0] STAT_RESET     = 8'hFF;
   localparam logic [STAT_W-1:0] STAT_CLEAR     = 8'h00;

   // chip mode control register 1
   localparam logic [7:0]        MODE_CTRL1_ADDR     = 8'h03;
   localparam logic [7:0]        MODE_CTRL1_RESET    = 8'h00;
   localparam int                MODE_CTRL1_LIVE_BIT = 4;

   // crystal trim registers
   localparam int                COARSE_W       = 5;
   localparam int                FINE_W         = 4;
   localparam int                TRIM_W         = COARSE_W + FINE_W;
   localparam logic [COARSE_W-1:0] COARSE_RESET = 5'h10;
   localparam logic [FINE_W-1:0] FINE_RESET     = 4'h0;
   localparam logic [TRIM_W-1:0] TRIM_OFF       = 9'h000;

   // digital supply brown-out threshold, millivolts (analogue detector)
   localparam int                BROWNOUT_MV    = 2450;

   // delay counters
   localparam int                CNT_W          = 16;
   localparam logic [CNT_W-1:0]  CNT_ZERO       = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE        = 16'h0001;

   // serial number width
   localparam int                SERIAL_W       = 32;

   // supply and reset supervisor
   typedef enum logic [2:0] {
      SUP_OFF   = 3'h0,
      SUP_BROWN = 3'h1,
      SUP_PULSE = 3'h2,
      SUP_HOLD  = 3'h3,
      SUP_RUN   = 3'h4
   } sup_state_type;

   // operating mode after reset
   typedef enum logic [1:0] {
      MODE_SLEEP = 2'h0,
      MODE_OSC   = 2'h1,
      MODE_PATH  = 2'h2,
      MODE_RX    = 2'h3
   } mode_type;

endpackage

// ### core_reset_sync.sv
// reset synchroniser: asserts at once, releases on the clock
`timescale 1ns/10ps
module core_reset_sync (
   // clock and enable
   input  wire logic ref_clk_i,
   input  wire logic clk_en_i,
   // combined asynchronous reset request, active low
   input  wire logic req_n_i,
   // synchronised reset, active low
   output logic      rst_n_o
);

   logic meta_r;
   logic sync_r;

   // only the second stage is read, so a late release cannot go metastable
   always_ff @(posedge ref_clk_i or negedge req_n_i) begin
      if (!req_n_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else if (clk_en_i) begin
         meta_r <= 1'b1;
         sync_r <= meta_r;
      end
   end

   assign rst_n_o = sync_r;

endmodule

// ### power_reset_sequencer.sv
// power-down, power-on and brown-out reset sequencing with sleep wake order
`timescale 1ns/10ps
module power_reset_sequencer #(
   parameter logic [15:0] T_RESET_CYC = 16'h03E8,
   parameter logic [15:0] T_OSC_CYC   = 16'h01F4,
   parameter logic [15:0] T_RF_CYC    = 16'h01F4,
   // arbitrary value, to be fused per device
   parameter logic [31:0] SERIAL_NUM  = 32'h5A5A_0001
) (
   // clock, reset, enable
   input  wire logic         ref_clk_i,
   input  wire logic         arst_n_i,
   input  wire logic         clk_en_i,
   // supply monitors
   input  wire logic         power_on_i,
   input  wire logic         brownout_i,
   // host commands
   input  wire logic         run_req_i,
   input  wire logic         sleep_req_i,
   input  wire logic         is_read_i,
   input  wire logic [7:0]   irq_event_i,
   input  wire logic         trim_coarse_wr_i,
   input  wire logic [4:0]   trim_coarse_i,
   input  wire logic         trim_fine_wr_i,
   input  wire logic [3:0]   trim_fine_i,
   input  wire logic         chip_mode_ctrl1_wr_i,
   input  wire logic [7:0]   chip_mode_ctrl1_i,
   // register views
   output logic [7:0]        interrupt_status_o,
   output logic [7:0]        chip_mode_ctrl1_o,
   output logic [31:0]       serial_number_o,
   // power and reset
   output logic              power_down_o,
   output logic              dig_reg_en_o,
   output logic              ana_reg_en_o,
   output logic              core_reset_o,
   output logic              irq_n_strobe_pin_o,
   // receiver control
   output logic              sleep_mode_o,
   output logic              rx_run_o,
   output logic              osc_high_prec_o,
   output logic [8:0]        trim_cap_o,
   output logic              rf_path_en_o,
   output logic              rx_ready_o
);

   power_reset_sequencer_pkg::sup_state_type sup_state_r;
   power_reset_sequencer_pkg::mode_type      mode_r;

   logic [15:0] hold_cnt_r;
   logic [15:0] wake_cnt_r;
   logic        core_go_r;
   logic        core_rst_n;
   logic        irq_n_r;
   logic [7:0]  status_r;
   logic [7:0]  mode_ctrl1_r;
   logic [4:0]  coarse_r;
   logic [3:0]  fine_r;
   logic [8:0]  trim_cap_r;
   logic        live_en;

   function automatic logic is_run(input power_reset_sequencer_pkg::mode_type m);
      is_run = (m != power_reset_sequencer_pkg::MODE_SLEEP);
   endfunction

   // supply supervisor; power-on and brown-out pre-empt every state
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sup_state_r <= power_reset_sequencer_pkg::SUP_OFF;
      end else if (clk_en_i) begin
         if (!power_on_i) begin
            sup_state_r <= power_reset_sequencer_pkg::SUP_OFF;
         end else if (brownout_i) begin
            sup_state_r <= power_reset_sequencer_pkg::SUP_BROWN;
         end else begin
            unique case (sup_state_r)
               power_reset_sequencer_pkg::SUP_OFF: begin
                  sup_state_r <= power_reset_sequencer_pkg::SUP_HOLD;
               end
               power_reset_sequencer_pkg::SUP_BROWN: begin
                  sup_state_r <= power_reset_sequencer_pkg::SUP_PULSE;
               end
               power_reset_sequencer_pkg::SUP_PULSE: begin
                  sup_state_r <= power_reset_sequencer_pkg::SUP_HOLD;
               end
               power_reset_sequencer_pkg::SUP_HOLD: begin
                  if (hold_cnt_r == T_RESET_CYC - power_reset_sequencer_pkg::CNT_ONE) begin
                     sup_state_r <= power_reset_sequencer_pkg::SUP_RUN;
                  end
               end
               power_reset_sequencer_pkg::SUP_RUN: begin
                  sup_state_r <= power_reset_sequencer_pkg::SUP_RUN;
               end
               default: begin
                  sup_state_r <= power_reset_sequencer_pkg::SUP_OFF;
               end
            endcase
         end
      end
   end

   // reset hold counter
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_cnt_r <= power_reset_sequencer_pkg::CNT_ZERO;
      end else if (clk_en_i) begin
         if (sup_state_r == power_reset_sequencer_pkg::SUP_HOLD && power_on_i && !brownout_i) begin
            hold_cnt_r <= hold_cnt_r + power_reset_sequencer_pkg::CNT_ONE;
         end else begin
            hold_cnt_r <= power_reset_sequencer_pkg::CNT_ZERO;
         end
      end
   end

   // flop before the async request so no decoder glitch reaches a reset pin
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         core_go_r <= 1'b0;
      end else if (clk_en_i) begin
         core_go_r <= (sup_state_r == power_reset_sequencer_pkg::SUP_RUN);
      end
   end

   core_reset_sync u_core_reset_sync (
      .ref_clk_i (ref_clk_i),
      .clk_en_i  (clk_en_i),
      .req_n_i   (arst_n_i & power_on_i & ~brownout_i & core_go_r),
      .rst_n_o   (core_rst_n)
   );

   // interrupt pin; the pin level is undefined only below the functional threshold
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_n_r <= 1'b0;
      end else if (clk_en_i) begin
         unique case (sup_state_r)
            power_reset_sequencer_pkg::SUP_PULSE: irq_n_r <= 1'b1;
            power_reset_sequencer_pkg::SUP_RUN:   irq_n_r <= core_rst_n && (status_r == power_reset_sequencer_pkg::STAT_CLEAR);
            default:                              irq_n_r <= 1'b0;
         endcase
      end
   end

   // status bits: reset to all ones, cleared by a read, a new event wins over the clear
   genvar gi;
   generate
      for (gi = 0; gi < power_reset_sequencer_pkg::STAT_W; gi++) begin : g_status
         always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
            if (!core_rst_n) begin
               status_r[gi] <= power_reset_sequencer_pkg::STAT_RESET[gi];
            end else if (clk_en_i) begin
               if (irq_event_i[gi]) begin
                  status_r[gi] <= 1'b1;
               end else if (is_read_i) begin
                  status_r[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // host-written configuration
   always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mode_ctrl1_r <= power_reset_sequencer_pkg::MODE_CTRL1_RESET;
         coarse_r <= power_reset_sequencer_pkg::COARSE_RESET;
         fine_r   <= power_reset_sequencer_pkg::FINE_RESET;
      end else if (clk_en_i) begin
         if (chip_mode_ctrl1_wr_i) begin
            mode_ctrl1_r <= chip_mode_ctrl1_i;
         end
         if (trim_coarse_wr_i) begin
            coarse_r <= trim_coarse_i;
         end
         if (trim_fine_wr_i) begin
            fine_r <= trim_fine_i;
         end
      end
   end

   assign live_en = mode_ctrl1_r[power_reset_sequencer_pkg::MODE_CTRL1_LIVE_BIT];

   // mode sequencer; sleep request wins over a wake request
   always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mode_r     <= power_reset_sequencer_pkg::MODE_SLEEP;
         wake_cnt_r <= power_reset_sequencer_pkg::CNT_ZERO;
      end else if (clk_en_i) begin
         wake_cnt_r <= wake_cnt_r + power_reset_sequencer_pkg::CNT_ONE;
         if (sleep_req_i) begin
            mode_r <= power_reset_sequencer_pkg::MODE_SLEEP;
         end else begin
            unique case (mode_r)
               power_reset_sequencer_pkg::MODE_SLEEP: begin
                  wake_cnt_r <= power_reset_sequencer_pkg::CNT_ZERO;
                  if (run_req_i) begin
                     mode_r <= power_reset_sequencer_pkg::MODE_OSC;
                  end
               end
               power_reset_sequencer_pkg::MODE_OSC: begin
                  if (wake_cnt_r == T_OSC_CYC - power_reset_sequencer_pkg::CNT_ONE) begin
                     mode_r     <= power_reset_sequencer_pkg::MODE_PATH;
                     wake_cnt_r <= power_reset_sequencer_pkg::CNT_ZERO;
                  end
               end
               power_reset_sequencer_pkg::MODE_PATH: begin
                  if (wake_cnt_r == T_RF_CYC - power_reset_sequencer_pkg::CNT_ONE) begin
                     mode_r <= power_reset_sequencer_pkg::MODE_RX;
                  end
               end
               power_reset_sequencer_pkg::MODE_RX: begin
                  wake_cnt_r <= power_reset_sequencer_pkg::CNT_ZERO;
               end
            endcase
         end
      end
   end

   // trim capacitors: latched on wake, live only when enabled
   always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         trim_cap_r <= power_reset_sequencer_pkg::TRIM_OFF;
      end else if (clk_en_i) begin
         if (sleep_req_i || (!is_run(mode_r) && !run_req_i)) begin
            trim_cap_r <= power_reset_sequencer_pkg::TRIM_OFF;
         end else if (!is_run(mode_r) || live_en) begin
            trim_cap_r <= {coarse_r, fine_r};
         end
      end
   end

   assign power_down_o       = (sup_state_r == power_reset_sequencer_pkg::SUP_OFF);
   assign dig_reg_en_o       = !power_down_o;
   assign core_reset_o       = !core_rst_n;
   assign rx_run_o           = core_rst_n && is_run(mode_r);
   assign ana_reg_en_o       = rx_run_o;
   assign sleep_mode_o       = core_rst_n && !is_run(mode_r);
   assign osc_high_prec_o    = rx_run_o;
   assign rf_path_en_o       = core_rst_n && (mode_r == power_reset_sequencer_pkg::MODE_PATH
                                           || mode_r == power_reset_sequencer_pkg::MODE_RX);
   assign rx_ready_o         = core_rst_n && (mode_r == power_reset_sequencer_pkg::MODE_RX);
   assign trim_cap_o         = trim_cap_r;
   assign irq_n_strobe_pin_o = irq_n_r;
   assign interrupt_status_o = status_r;
   assign chip_mode_ctrl1_o  = mode_ctrl1_r;
   assign serial_number_o    = SERIAL_NUM;

   // checks
   pdown_off_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (!power_on_i && clk_en_i) |=> (power_down_o && !dig_reg_en_o && !ana_reg_en_o))
      else $error("power-down not entered");

   por_start_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (arst_n_i && sup_state_r == power_reset_sequencer_pkg::SUP_OFF && power_on_i && !brownout_i && clk_en_i)
      |=> (dig_reg_en_o && sup_state_r == power_reset_sequencer_pkg::SUP_HOLD && core_reset_o))
      else $error("power-on reset not started");

   ana_reg_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (ana_reg_en_o == rx_run_o) && !(ana_reg_en_o && (power_down_o || core_reset_o || sleep_mode_o)))
      else $error("analogue regulator on without rf active");

   brown_rst_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (brownout_i && power_on_i && clk_en_i) |=> (core_reset_o && !irq_n_r ##1 core_reset_o))
      else $error("brown-out did not reset");

   brown_irq_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (sup_state_r == power_reset_sequencer_pkg::SUP_BROWN && clk_en_i && brownout_i)
      |=> !irq_n_strobe_pin_o)
      else $error("interrupt not low in brown-out");

   recov_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (sup_state_r == power_reset_sequencer_pkg::SUP_BROWN && !brownout_i && power_on_i && clk_en_i)
      ##1 (clk_en_i && !brownout_i && power_on_i)
      |=> (irq_n_strobe_pin_o ##1 (!irq_n_strobe_pin_o || !clk_en_i)))
      else $error("recovery pulse missing");

   hold_len_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (sup_state_r == power_reset_sequencer_pkg::SUP_RUN && $past(sup_state_r) != power_reset_sequencer_pkg::SUP_RUN)
      |-> ($past(hold_cnt_r) == T_RESET_CYC - power_reset_sequencer_pkg::CNT_ONE))
      else $error("reset hold length wrong");

   is_reset_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(core_rst_n) |-> (status_r == power_reset_sequencer_pkg::STAT_RESET && !irq_n_strobe_pin_o
                             && sleep_mode_o))
      else $error("status not all ones after reset");

   first_read_a: assert property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      (is_read_i && irq_event_i == power_reset_sequencer_pkg::STAT_CLEAR && clk_en_i
       && sup_state_r == power_reset_sequencer_pkg::SUP_RUN && power_on_i && !brownout_i)
      ##1 (clk_en_i && power_on_i && !brownout_i && irq_event_i == power_reset_sequencer_pkg::STAT_CLEAR)
      |=> irq_n_strobe_pin_o)
      else $error("interrupt not released by read");

   sleep_trim_a: assert property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      (sleep_mode_o && !$past(run_req_i)) |-> (trim_cap_o == power_reset_sequencer_pkg::TRIM_OFF
                                              && !osc_high_prec_o))
      else $error("trim connected in sleep");

   wake_trim_a: assert property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      (sleep_mode_o && run_req_i && !sleep_req_i && clk_en_i)
      |=> (trim_cap_o == {$past(coarse_r), $past(fine_r)} && rx_run_o))
      else $error("trim not loaded on wake");

   trim_hold_a: assert property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      (rx_run_o && !live_en && !sleep_req_i && clk_en_i)
      |=> $stable(trim_cap_o))
      else $error("trim changed without live enable");

   wake_order_a: assert property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      $rose(rf_path_en_o) |-> ($past(osc_high_prec_o) && !rx_ready_o))
      else $error("wake order broken");

   wake_cover_c: cover property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      $rose(rx_ready_o));

   recov_cover_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      sup_state_r == power_reset_sequencer_pkg::SUP_PULSE);

   read_cover_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(irq_n_strobe_pin_o) && sup_state_r == power_reset_sequencer_pkg::SUP_RUN);

   live_cover_c: cover property (@(posedge ref_clk_i) disable iff (!core_rst_n)
      rx_run_o && live_en && trim_fine_wr_i);

endmodule

// ### host_model.sv
// host processor model: power-on pin and register command strobes
`timescale 1ns/10ps
module host_model (
   // clock and device state
   input  wire logic       ref_clk_i,
   input  wire logic       core_reset_i,
   // power-on pin
   output logic            power_on_o,
   // command strobes and data
   output logic            run_req_o,
   output logic            sleep_req_o,
   output logic            is_read_o,
   output logic            coarse_wr_o,
   output logic [4:0]      coarse_o,
   output logic            fine_wr_o,
   output logic [3:0]      fine_o,
   output logic            mode_wr_o,
   output logic [7:0]      mode_o
);
   initial begin
      power_on_o = 1'b1;
      {run_req_o, sleep_req_o, is_read_o, coarse_wr_o, fine_wr_o, mode_wr_o} = 6'h00;
      {coarse_o, fine_o, mode_o} = 17'h00000;
   end

   // any low phase forces a device reset at once, with no minimum pulse length
   task automatic set_power(input logic level);
      @(posedge ref_clk_i);
      power_on_o <= level;
   endtask

   // kind: 0 run, 1 sleep, 2 status read, 3 coarse, 4 fine, 5 mode reg 1
   task automatic command(input int kind, input logic [7:0] data);
      int n;
      n = 0;
      while (core_reset_i !== 1'b0 && n < 200) begin
         @(posedge ref_clk_i);
         n++;
      end
      @(posedge ref_clk_i);
      case (kind)
         0: run_req_o <= 1'b1;
         1: sleep_req_o <= 1'b1;
         2: is_read_o <= 1'b1;
         3: {coarse_wr_o, coarse_o} <= {1'b1, data[4:0]};
         4: {fine_wr_o, fine_o} <= {1'b1, data[3:0]};
         default: {mode_wr_o, mode_o} <= {1'b1, data};
      endcase
      @(posedge ref_clk_i);
      {run_req_o, sleep_req_o, is_read_o, coarse_wr_o, fine_wr_o, mode_wr_o} <= 6'h00;
      // idle data lines never keep the last value
      {coarse_o, fine_o, mode_o} <= ~{coarse_o, fine_o, mode_o};
   endtask
endmodule

// ### test_power_reset_sequencer.sv
// self-checking bench for the power and reset sequencer
`timescale 1ns/10ps
module test_power_reset_sequencer;
   localparam logic [15:0] T_RESET = 16'h0004;
   localparam logic [15:0] T_OSC   = 16'h0003;
   localparam logic [15:0] T_RF    = 16'h0003;
   // arbitrary value
   localparam logic [31:0] SERIAL  = 32'h1234_5678;
   logic       clk, arst_n, brownout, power_on, run_req, sleep_req, is_read;
   logic       clk_en, coarse_wr, fine_wr, mode_wr, power_down, dig_reg_en, ana_reg_en, core_reset;
   logic       irq_n, sleep_mode, rx_run, osc_high_prec, rf_path_en, rx_ready;
   logic [7:0] irq_event, status, mode_val, mode_view, ev, cm;
   logic [4:0] coarse, co, nc;
   logic [3:0] fine, fi;
   logic [8:0] trim_cap;
   logic [31:0] serial_number;
   int         mismatches, comparisons, hi, p, f;

   power_reset_sequencer #(.T_RESET_CYC(T_RESET), .T_OSC_CYC(T_OSC), .T_RF_CYC(T_RF), .SERIAL_NUM(SERIAL)) dut_u (
      .ref_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(clk_en), .power_on_i(power_on), .brownout_i(brownout),
      .run_req_i(run_req), .sleep_req_i(sleep_req), .is_read_i(is_read), .irq_event_i(irq_event),
      .trim_coarse_wr_i(coarse_wr), .trim_coarse_i(coarse), .trim_fine_wr_i(fine_wr), .trim_fine_i(fine),
      .chip_mode_ctrl1_wr_i(mode_wr), .chip_mode_ctrl1_i(mode_val), .interrupt_status_o(status),
      .chip_mode_ctrl1_o(mode_view), .serial_number_o(serial_number), .power_down_o(power_down),
      .dig_reg_en_o(dig_reg_en), .ana_reg_en_o(ana_reg_en), .core_reset_o(core_reset),
      .irq_n_strobe_pin_o(irq_n), .sleep_mode_o(sleep_mode), .rx_run_o(rx_run),
      .osc_high_prec_o(osc_high_prec), .trim_cap_o(trim_cap), .rf_path_en_o(rf_path_en), .rx_ready_o(rx_ready));

   host_model host_u (
      .ref_clk_i(clk), .core_reset_i(core_reset), .power_on_o(power_on), .run_req_o(run_req),
      .sleep_req_o(sleep_req), .is_read_o(is_read), .coarse_wr_o(coarse_wr), .coarse_o(coarse),
      .fine_wr_o(fine_wr), .fine_o(fine), .mode_wr_o(mode_wr), .mode_o(mode_val));

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   // sample just after the edge so the design's updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic leave_reset();
      int n;
      n = 0;
      while (core_reset !== 1'b0 && n < 100) begin
         tick(1);
         n++;
      end
      check(n < 100, "core stuck in reset");
      check(status === 8'hFF && irq_n === 1'b0, "status after reset");
      check(sleep_mode === 1'b1 && rx_run === 1'b0, "sleep after reset");
      check(trim_cap === 9'h000 && mode_view === 8'h00, "trim and mode reg reset");
   endtask

   function automatic logic [8:0] trim_of(input logic [4:0] c, input logic [3:0] t);
      return {c, t};
   endfunction

   task automatic wake();
      host_u.command(0, 8'h00);
      #1;
      check(rx_run === 1'b1 && ana_reg_en === 1'b1 && osc_high_prec === 1'b1, "wake step one");
      check(rf_path_en === 1'b0 && rx_ready === 1'b0, "path before oscillator");
      tick(int'(T_OSC) - 1);
      check(rf_path_en === 1'b0, "path early");
      tick(1);
      check(rf_path_en === 1'b1 && rx_ready === 1'b0, "path on");
      tick(int'(T_RF) - 1);
      check(rx_ready === 1'b0, "ready early");
      tick(1);
      check(rx_ready === 1'b1, "ready on");
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   initial begin
      {arst_n, brownout, irq_event, mismatches, comparisons} = '0;
      clk_en = 1'b1;
      void'($urandom(18695));
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      leave_reset();
      check(serial_number === SERIAL, "serial number");
      host_u.command(2, 8'h00);
      tick(1);
      check(status === 8'h00 && irq_n === 1'b1, "first read");
      ev = 8'($urandom_range(255, 1));
      @(posedge clk);
      irq_event <= ev;
      @(posedge clk);
      irq_event <= 8'h00;
      tick(1);
      check(status === ev && irq_n === 1'b0, "event sets status");
      host_u.command(2, 8'h00);
      for (int i = 0; i < 3; i++) begin
         co = 5'($urandom());
         fi = 4'($urandom());
         host_u.command(3, {3'h0, co});
         host_u.command(4, {4'h0, fi});
         tick(1);
         check(trim_cap === 9'h000 && osc_high_prec === 1'b0, "sleep trim off");
         wake();
         check(trim_cap === trim_of(co, fi), "wake trim");
         cm = 8'($urandom());
         cm[4] = (i != 0);
         host_u.command(5, cm);
         #1;
         check(mode_view === cm, "mode reg write");
         nc = co ^ 5'h15;
         host_u.command(3, {3'h0, nc});
         // a live update lands one edge after the register write
         tick(1);
         check(trim_cap === trim_of(cm[4] ? nc : co, fi), "run trim write");
         host_u.command(1, 8'h00);
         #1;
         check(rx_run === 1'b0 && ana_reg_en === 1'b0 && trim_cap === 9'h000, "sleep");
      end
      wake();
      @(posedge clk);
      brownout <= 1'b1;
      #1;
      check(core_reset === 1'b1, "brown-out reset");
      tick(6);
      check(irq_n === 1'b0 && rx_run === 1'b0, "pin low in brown-out");
      @(posedge clk);
      brownout <= 1'b0;
      {hi, p, f} = {32'sd0, -32'sd1, -32'sd1};
      for (int k = 0; k < 40; k++) begin
         tick(1);
         if (irq_n === 1'b1) {hi, p} = {hi + 1, k};
         if (core_reset === 1'b0 && f < 0) f = k;
      end
      check(hi == 1 && f - p >= int'(T_RESET), "recovery pulse and hold");
      leave_reset();
      wake();
      // enable low: a sleep command must not be taken, state stays frozen
      @(posedge clk);
      clk_en <= 1'b0;
      host_u.command(1, 8'h00);
      tick(2);
      check(rx_ready === 1'b1 && rx_run === 1'b1 && sleep_mode === 1'b0, "enable low freezes state");
      @(posedge clk);
      clk_en <= 1'b1;
      host_u.set_power(1'b0);
      #1;
      check(core_reset === 1'b1, "async core reset");
      tick(3);
      check(power_down === 1'b1 && dig_reg_en === 1'b0 && ana_reg_en === 1'b0, "power down");
      host_u.set_power(1'b1);
      tick(1);
      check(dig_reg_en === 1'b1 && core_reset === 1'b1, "power on reset");
      leave_reset();
      complete_run();
   end
endmodule
